// >>> include/touch_key_pkg.sv
// Package with register map, field positions and constants of the touch key sense counter.
// Overview of operation
// - The block holds one 24-bit gate timer and one 24-bit event counter whose clocks follow the mode bit.
// - With mode zero the counter counts internal clock cycles and the gate timer counts sensing clock cycles.
// - With mode one the roles swap, so the counter counts sensing cycles and the timer runs on the internal clock.
// - A start command clears the counter, loads the timer with its period and then runs both.
// - When the timer expires the counter value is latched as the captured count and an interrupt is raised.
// - A fast and a slow moving average of the captured count are both updated on every capture.
// - Software can read the captured count and both averages after a capture.
// - Auto mode repeats gate and capture cycles continuously without a per-capture interrupt.
// - Auto mode limits the timer, the captured count and both averages to 16 bits.
// - Auto mode compares the averages and raises a wake-up interrupt when fast exceeds slow by more than a threshold.
// - The logic keeps working when clocked from the slow internal oscillator during sleep.
package touch_key_pkg;
    localparam int unsigned DATA_W = 24;
    localparam int unsigned AUTO_W = 16;
    localparam int unsigned ADDR_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 16'hA130;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 16'hA134;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD = 16'hA138;
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE = 16'hA13C;
    localparam logic [ADDR_W-1:0] ADDR_FAST = 16'hA140;
    localparam logic [ADDR_W-1:0] ADDR_SLOW = 16'hA144;
    localparam logic [ADDR_W-1:0] ADDR_THRESHOLD = 16'hA148;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'hA14C;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam int unsigned CFG_MODE_BIT = 0;
    localparam int unsigned CFG_AUTO_BIT = 1;
    localparam int unsigned CTL_START_BIT = 0;
    localparam int unsigned CTL_STOP_BIT = 1;
    localparam int unsigned ST_DONE_BIT = 0;
    localparam int unsigned ST_WAKE_BIT = 1;
    localparam int unsigned ST_BUSY_BIT = 2;
    localparam int unsigned FAST_SHIFT = 2;
    localparam int unsigned SLOW_SHIFT = 5;
    localparam logic [DATA_W-1:0] AUTO_MASK = 24'h00FFFF;
    localparam logic [DATA_W-1:0] ZERO_WORD = 24'h000000;
    localparam logic [DATA_W-1:0] ONE_WORD = 24'h000001;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_RUN
    } meas_state_e;
endpackage

// >>> hw/moving_average.sv
// Exponential moving-average filter with a fixed shift.
`timescale 1ns/1ps
module moving_average #(
    parameter int unsigned SHIFT = 1
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_srst,
    // Seed from software.
    input wire logic i_seed_valid,
    input wire logic [touch_key_pkg::DATA_W-1:0] i_seed,
    // Capture sample.
    input wire logic i_sample_valid,
    input wire logic [touch_key_pkg::DATA_W-1:0] i_sample,
    input wire logic [touch_key_pkg::DATA_W-1:0] i_mask,
    // Result.
    output logic [touch_key_pkg::DATA_W-1:0] o_average
);
    import touch_key_pkg::*;
    logic [DATA_W-1:0] avg_q;
    logic [DATA_W-1:0] avg_d;
    logic signed [DATA_W:0] diff;
    logic signed [DATA_W:0] step;
    logic [DATA_W:0] sum;
    assign diff = $signed({1'b0, i_sample}) - $signed({1'b0, avg_q});
    assign step = diff >>> SHIFT;
    assign sum = {1'b0, avg_q} + $unsigned(step);
    assign avg_d = i_seed_valid ? (i_seed & i_mask) :
                   i_sample_valid ? (sum[DATA_W-1:0] & i_mask) : avg_q;
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            avg_q <= ZERO_WORD;
        end else begin
            avg_q <= avg_d;
        end
    end
    assign o_average = avg_q;
endmodule

// >>> hw/touch_key_sense_counter.sv
// Touch key sense counter with gate timer, capture, averaging and auto wake detection.
`timescale 1ns/1ps
module touch_key_sense_counter (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_srst,
    // Sensing oscillator pin.
    input wire logic i_sense_clock,
    // Avalon-MM slave.
    input wire logic [touch_key_pkg::ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Events.
    output logic o_capture_irq,
    output logic o_wake_irq
);
    import touch_key_pkg::*;

    // Synchroniser and edge detection of the sensing clock.
    logic sense_meta_q;
    logic sense_sync_q;
    logic sense_prev_q;
    logic sense_edge;

    logic [7:0] config_q;
    logic [DATA_W-1:0] period_q;
    logic [DATA_W-1:0] threshold_q;
    logic [DATA_W-1:0] capture_q;
    logic [DATA_W-1:0] timer_q;
    logic [DATA_W-1:0] timer_d;
    logic [DATA_W-1:0] counter_q;
    logic [DATA_W-1:0] counter_d;
    logic done_q;
    logic wake_q;
    logic ack_q;
    logic [31:0] rdata_q;
    meas_state_e state_q;
    meas_state_e state_d;

    logic mode_sel;
    logic auto_sel;
    logic [DATA_W-1:0] width_mask;
    logic timer_tick;
    logic count_tick;
    logic expire;
    logic capture_now;
    logic access;
    logic wr_go;
    logic wr_config;
    logic wr_control;
    logic wr_period;
    logic wr_fast;
    logic wr_slow;
    logic wr_threshold;
    logic wr_status;
    logic start_cmd;
    logic stop_cmd;
    logic [DATA_W-1:0] fast_avg;
    logic [DATA_W-1:0] slow_avg;
    logic [DATA_W:0] wake_limit;
    logic wake_event;
    logic [DATA_W-1:0] wdata24;
    logic [31:0] rdata_d;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    // Sensing clock sampled on the system clock.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            sense_meta_q <= 1'b0;
            sense_sync_q <= 1'b0;
            sense_prev_q <= 1'b0;
        end else begin
            sense_meta_q <= i_sense_clock;
            sense_sync_q <= sense_meta_q;
            sense_prev_q <= sense_sync_q;
        end
    end
    assign sense_edge = sense_sync_q & ~sense_prev_q;

    // Bus decode.
    assign access = i_read | i_write;
    assign wr_go = i_write & ack_q;
    assign wr_config = wr_go & hit(i_address, ADDR_CONFIG) & i_byteenable[0];
    assign wr_control = wr_go & hit(i_address, ADDR_CONTROL) & i_byteenable[0];
    assign wr_period = wr_go & hit(i_address, ADDR_PERIOD);
    assign wr_fast = wr_go & hit(i_address, ADDR_FAST);
    assign wr_slow = wr_go & hit(i_address, ADDR_SLOW);
    assign wr_threshold = wr_go & hit(i_address, ADDR_THRESHOLD);
    assign wr_status = wr_go & hit(i_address, ADDR_STATUS) & i_byteenable[0];
    assign wdata24 = i_writedata[DATA_W-1:0];
    assign start_cmd = wr_control & i_writedata[CTL_START_BIT];
    assign stop_cmd = wr_control & i_writedata[CTL_STOP_BIT];
    assign o_waitrequest = access & ~ack_q;

    assign mode_sel = config_q[CFG_MODE_BIT];
    assign auto_sel = config_q[CFG_AUTO_BIT];
    assign width_mask = auto_sel ? AUTO_MASK : {DATA_W{1'b1}};

    assign timer_tick = mode_sel ? 1'b1 : sense_edge;
    assign count_tick = mode_sel ? sense_edge : 1'b1;

    assign expire = (state_q == ST_RUN) && timer_tick && (timer_q <= ONE_WORD);
    assign capture_now = expire;

    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        counter_d = counter_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start_cmd) begin
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                counter_d = ZERO_WORD;
                timer_d = period_q & width_mask;
                state_d = ST_RUN;
            end
            ST_RUN: begin
                if (timer_tick) begin
                    timer_d = timer_q - ONE_WORD;
                end
                if (count_tick) begin
                    counter_d = (counter_q + ONE_WORD) & width_mask;
                end
                if (expire) begin
                    state_d = auto_sel ? ST_LOAD : ST_IDLE;
                end
            end
        endcase
        if (stop_cmd) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_q <= ST_IDLE;
            timer_q <= ZERO_WORD;
            counter_q <= ZERO_WORD;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            counter_q <= counter_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            capture_q <= ZERO_WORD;
        end else if (capture_now) begin
            capture_q <= counter_q & width_mask;
        end
    end

    // Fast and slow filters updated on capture.
    // Software seeds the averages by writing them.
    moving_average #(
        .SHIFT(FAST_SHIFT)
    ) u_fast (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_seed_valid(wr_fast),
        .i_seed(wdata24),
        .i_sample_valid(capture_now),
        .i_sample(counter_q & width_mask),
        .i_mask(width_mask),
        .o_average(fast_avg)
    );
    moving_average #(
        .SHIFT(SLOW_SHIFT)
    ) u_slow (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_seed_valid(wr_slow),
        .i_seed(wdata24),
        .i_sample_valid(capture_now),
        .i_sample(counter_q & width_mask),
        .i_mask(width_mask),
        .o_average(slow_avg)
    );

    assign wake_limit = {1'b0, slow_avg} + {1'b0, threshold_q & width_mask};
    assign wake_event = auto_sel && ({1'b0, fast_avg} > wake_limit);

    // Configuration and sticky status; a set wins over a clear.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            config_q <= CONFIG_RESET;
            period_q <= ZERO_WORD;
            threshold_q <= ZERO_WORD;
            done_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            if (wr_config) begin
                config_q <= i_writedata[7:0];
            end
            if (wr_period) begin
                period_q <= wdata24;
            end
            if (wr_threshold) begin
                threshold_q <= wdata24;
            end
            // No capture interrupt in auto mode.
            if (capture_now && !auto_sel) begin
                done_q <= 1'b1;
            end else if (wr_status && i_writedata[ST_DONE_BIT]) begin
                done_q <= 1'b0;
            end
            if (wake_event) begin
                wake_q <= 1'b1;
            end else if (wr_status && i_writedata[ST_WAKE_BIT]) begin
                wake_q <= 1'b0;
            end
        end
    end
    assign o_capture_irq = done_q;
    assign o_wake_irq = wake_q;

    assign rdata_d = hit(i_address, ADDR_CONFIG) ? {24'h000000, config_q} :
                     hit(i_address, ADDR_PERIOD) ? {8'h00, period_q} :
                     hit(i_address, ADDR_CAPTURE) ? {8'h00, capture_q} :
                     hit(i_address, ADDR_FAST) ? {8'h00, fast_avg} :
                     hit(i_address, ADDR_SLOW) ? {8'h00, slow_avg} :
                     hit(i_address, ADDR_THRESHOLD) ? {8'h00, threshold_q} :
                     hit(i_address, ADDR_STATUS) ?
                         {29'h00000000, state_q != ST_IDLE, wake_q, done_q} :
                     32'h00000000;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= access & ~ack_q;
            if (i_read && !ack_q) begin
                rdata_q <= rdata_d;
            end
        end
    end
    assign o_readdata = rdata_q;
endmodule

// >>> verification/touch_sense_osc.sv
// Behavioural relaxation oscillator that stands on the sensing pin.
`timescale 1ns/1ps
module touch_sense_osc (
    // Control.
    input wire logic i_run,
    input wire logic [15:0] i_half_ns,
    // Sensing clock.
    output logic o_sense
);
    initial begin
        o_sense = 1'b0;
        forever begin
            if (i_run) begin
                #(i_half_ns) o_sense = ~o_sense;
            end else begin
                #10 o_sense = 1'b0;
            end
        end
    end
endmodule

// >>> verification/touch_key_sense_counter_sva.sv
// Checker for the bus timing and event outputs of the touch key sense counter.
`timescale 1ns/1ps
module touch_key_sense_counter_sva (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_srst,
    // Watched ports.
    input wire logic i_sense_clock,
    input wire logic [touch_key_pkg::ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic o_capture_irq,
    input wire logic o_wake_irq
);
    import touch_key_pkg::*;
    logic auto_q;
    wire logic cfg_wr = i_write && !o_waitrequest && i_address == ADDR_CONFIG && i_byteenable[0];
    wire logic st_wr = i_write && !o_waitrequest && i_address == ADDR_STATUS && i_byteenable[0];
    wire logic rd_ok = i_read && !o_waitrequest;
    wire logic is_val = i_address inside {ADDR_CAPTURE, ADDR_FAST, ADDR_SLOW};
    wire logic mapped = i_address >= ADDR_CONFIG && i_address <= ADDR_STATUS && !i_address[1:0];
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            auto_q <= 1'b0;
        end else if (cfg_wr) begin
            auto_q <= i_writedata[CFG_AUTO_BIT];
        end
    end
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (i_srst);
    property p_one_wait;
        ($rose(i_read) || $rose(i_write)) |-> o_waitrequest ##1 !o_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("Request did not get exactly one wait state.");
    property p_idle;
        !(i_read || i_write) |-> !o_waitrequest;
    endproperty
    a_idle: assert property (p_idle)
        else $error("Wait asserted with no request.");
    property p_top_zero;
        rd_ok |-> o_readdata[31:24] == 8'h00;
    endproperty
    a_top_zero: assert property (p_top_zero)
        else $error("Read data wider than 24 bits.");
    property p_unmapped;
        rd_ok && !mapped |-> o_readdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped read not zero.");
    property p_auto_width;
        rd_ok && auto_q && is_val |-> o_readdata[23:16] == 8'h00;
    endproperty
    a_auto_width: assert property (p_auto_width)
        else $error("Auto mode value wider than 16 bits.");
    property p_cap_quiet;
        auto_q && $past(auto_q) |-> !$rose(o_capture_irq);
    endproperty
    a_cap_quiet: assert property (p_cap_quiet)
        else $error("Capture event raised in auto mode.");
    property p_wake_auto;
        $rose(o_wake_irq) |-> $past(auto_q);
    endproperty
    a_wake_auto: assert property (p_wake_auto)
        else $error("Wake event outside auto mode.");
    property p_cap_hold;
        $fell(o_capture_irq) |-> $past(st_wr && i_writedata[ST_DONE_BIT]);
    endproperty
    a_cap_hold: assert property (p_cap_hold)
        else $error("Capture event dropped without clear.");
    property p_wake_hold;
        $fell(o_wake_irq) |-> $past(st_wr && i_writedata[ST_WAKE_BIT]);
    endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("Wake event dropped without clear.");
    c_cap: cover property ($rose(o_capture_irq));
    c_wake: cover property ($rose(o_wake_irq));
    c_unmapped: cover property (rd_ok && !mapped);
endmodule
bind touch_key_sense_counter touch_key_sense_counter_sva touch_key_sense_counter_sva_inst (
    .i_clock(i_clock), .i_srst(i_srst), .i_sense_clock(i_sense_clock),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_capture_irq(o_capture_irq), .o_wake_irq(o_wake_irq)
);

// >>> verification/touch_key_sense_counter_tb.sv
// Self-checking testbench for the touch key sense counter.
`timescale 1ns/1ps
module touch_key_sense_counter_tb;
    import touch_key_pkg::*;
    logic i_clock, i_srst, i_read, i_write, i_sense_clock, sense_run;
    logic o_waitrequest, o_capture_irq, o_wake_irq;
    logic [ADDR_W-1:0] i_address;
    logic [31:0] i_writedata, o_readdata, q;
    logic [3:0] i_byteenable;
    logic [15:0] half_ns;
    logic [23:0] cap;
    int n_errors = 0;
    int check_count = 0;
    touch_key_sense_counter touch_key_sense_counter_inst (.i_clock(i_clock), .i_srst(i_srst),
        .i_sense_clock(i_sense_clock), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .o_capture_irq(o_capture_irq), .o_wake_irq(o_wake_irq));
    touch_sense_osc touch_sense_osc_inst (.i_run(sense_run), .i_half_ns(half_ns),
        .o_sense(i_sense_clock));
    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end
    task automatic end_sim();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        i_address <= a;
        i_writedata <= d;
        i_write <= wr;
        i_read <= !wr;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 100);
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
        if (n >= 100) begin
            n_errors++;
            end_sim();
        end
    endtask
    task automatic wait_irq(input logic wake);
        int n;
        n = 0;
        while ((wake ? o_wake_irq : o_capture_irq) !== 1'b1 && n < 3000) begin
            @(negedge i_clock);
            n++;
        end
        chk({31'h0, wake ? o_wake_irq : o_capture_irq}, 32'h1);
        if (n >= 3000) begin
            end_sim();
        end
    endtask
    function automatic logic [23:0] avg(input logic [23:0] old, input logic [23:0] c, input int sh);
        return old + 24'($signed(c - old) >>> sh);
    endfunction
    task automatic measure(input logic [7:0] cfg, input logic [23:0] per, input logic [23:0] seed,
                           input logic [23:0] lo, input logic [23:0] hi);
        bus(1'b1, ADDR_CONFIG, {24'h0, cfg});
        bus(1'b1, ADDR_PERIOD, {8'h0, per});
        bus(1'b1, ADDR_FAST, {8'h0, seed});
        bus(1'b1, ADDR_SLOW, {8'h0, seed});
        bus(1'b1, ADDR_CONTROL, 32'h1);
        wait_irq(1'b0);
        bus(1'b0, ADDR_CAPTURE, 32'h0);
        cap = q[23:0];
        chk_rng(q, {8'h0, lo}, {8'h0, hi});
        bus(1'b0, ADDR_FAST, 32'h0);
        chk(q, {8'h0, avg(seed, cap, FAST_SHIFT)});
        bus(1'b0, ADDR_SLOW, 32'h0);
        chk(q, {8'h0, avg(seed, cap, SLOW_SHIFT)});
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q, 32'h1);
        bus(1'b1, ADDR_STATUS, 32'h1);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk({q[31:1], o_capture_irq}, 32'h0);
    endtask
    task automatic t_regs();
        bus(1'b0, ADDR_CONFIG, 32'h0);
        chk(q, {24'h0, CONFIG_RESET});
        i_byteenable <= 4'hE;
        bus(1'b1, ADDR_CONFIG, 32'h3);
        i_byteenable <= 4'hF;
        bus(1'b0, ADDR_CONFIG, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, ADDR_CONFIG, 32'h3);
        bus(1'b0, ADDR_CONFIG, 32'h0);
        chk(q, 32'h3);
        bus(1'b1, 16'hA150, 32'hFFFF);
        bus(1'b0, 16'hA150, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, ADDR_CONTROL, 32'h0);
        chk(q, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_mode0();
        measure(8'h00, 24'h8, 24'h20, 24'h30, 24'h50);
        $display("test mode0 done");
    endtask
    task automatic t_mode1();
        measure(8'h01, 24'h40, 24'h100, 24'h6, 24'h9);
        $display("test mode1 done");
    endtask
    task automatic t_auto();
        half_ns <= 16'd300;
        bus(1'b1, ADDR_THRESHOLD, 32'h10);
        bus(1'b1, ADDR_PERIOD, 32'h10008);
        bus(1'b1, ADDR_FAST, 32'h40);
        bus(1'b1, ADDR_SLOW, 32'h40);
        bus(1'b1, ADDR_CONFIG, 32'h2);
        bus(1'b1, ADDR_CONTROL, 32'h1);
        wait_irq(1'b1);
        chk({31'h0, o_capture_irq}, 32'h0);
        bus(1'b0, ADDR_CAPTURE, 32'h0);
        chk_rng(q, 32'hA8, 32'hCC);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q, 32'h6);
        bus(1'b1, ADDR_CONTROL, 32'h2);
        bus(1'b1, ADDR_CONFIG, 32'h0);
        bus(1'b1, ADDR_STATUS, 32'h2);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q, 32'h0);
        $display("test auto done");
    endtask
    initial begin
        i_srst = 1'b1;
        sense_run = 1'b1;
        half_ns = 16'd103;
        i_address = '0;
        i_read = 1'b0;
        i_write = 1'b0;
        i_writedata = 32'h0;
        i_byteenable = 4'hF;
        repeat (10) @(posedge i_clock);
        i_srst <= 1'b0;
        t_regs();
        t_mode0();
        t_mode1();
        t_auto();
        end_sim();
    end
endmodule
